// ==== logic/watchpoint_defines.vh ====
// Purpose: constants for the watchpoint comparator unit
// Assumes: byte addresses on a 12-bit classic Wishbone window
// Notes: definitions only
`ifndef WATCHPOINT_DEFINES_VH
`define WATCHPOINT_DEFINES_VH

`define WP_ADR_W 12
`define WP_OFF_COMP0 12'h020
`define WP_OFF_MASK0 12'h024
`define WP_OFF_FCT0 12'h028
`define WP_OFF_COMP1 12'h030
`define WP_OFF_MASK1 12'h034
`define WP_OFF_FCT1 12'h038
`define WP_OFF_IRQ_STATUS 12'h040
`define WP_OFF_IRQ_MASK 12'h044

`define WP_WORD_ZERO 32'h0000_0000
`define WP_WORD_ONES 32'hFFFF_FFFF
`define WP_BIT0_ONLY 32'h0000_0001
`define WP_LANE_BYTE 32'h0000_00FF
`define WP_LANE_HALF 32'h0000_FFFF

`define WP_REF_RESET 32'h0000_0000
`define WP_CNT_RESET 5'h00
`define WP_CNT_MAX 5'h18
`define WP_CNT_MSB 4
`define WP_FUNC_RESET 4'h0
`define WP_SIZE_RESET 2'h0

// ignore-count field of the mask register
`define WP_MASK_CNT 4:0
`define WP_MASK_FREE 31:5
// function register fields
`define WP_FCT_FUNC 3:0
`define WP_FCT_DMATCH 8
`define WP_FCT_DSIZE 11:10
`define WP_FCT_LINK 12
`define WP_FCT_HIT 24

`define WP_FUNC_OFF 4'h0
`define WP_FUNC_FETCH 4'h4
`define WP_FUNC_READ 4'h6
`define WP_FUNC_RDWR 4'h7

`define WP_SIZE_BYTE 2'h0
`define WP_SIZE_HALF 2'h1
`define WP_SIZE_WORD 2'h2

`define WP_IRQ_W 2
`define WP_IRQ_HIT0 0
`define WP_IRQ_HIT1 1
`define WP_IRQ_RESET 2'h0

`endif

// ==== logic/watch_comparator.v ====
// Purpose: one watchpoint comparator, address or data value match
// Assumes: watched transfer signals are synchronous and valid for one cycle
// Notes: purely combinational; the caller registers the hit
`timescale 1ns/1ps
`default_nettype none
`include "watchpoint_defines.vh"

module watch_comparator (
	input wire [31:0] refValue,
	input wire [4:0] ignoreCount,
	input wire [3:0] funcSel,
	input wire dataMode,
	input wire [1:0] dataSize,
	input wire linkGate,
	input wire busValid,
	input wire busFetch,
	input wire busWrite,
	input wire [31:0] busAddr,
	input wire [31:0] busData,
	output wire addrHit,
	output wire match
);

	function [31:0] ignoreBits;
		input [4:0] cnt;
		input fetchWatch;
		begin
			if (cnt == `WP_CNT_RESET) begin
				// fetches are at least halfword aligned
				ignoreBits = fetchWatch ? `WP_BIT0_ONLY : `WP_WORD_ZERO; // RL5
			end else begin
				ignoreBits = ~(`WP_WORD_ONES << cnt); // RL6
			end
		end
	endfunction

	function [31:0] laneMask;
		input [1:0] size;
		input [1:0] lane;
		begin
			case (size)
			`WP_SIZE_BYTE: laneMask = `WP_LANE_BYTE << {lane, 3'b000}; // RL13
			`WP_SIZE_HALF: laneMask = `WP_LANE_HALF << {lane[1], 4'b0000}; // RL13
			`WP_SIZE_WORD: laneMask = `WP_WORD_ONES; // RL13
			default: laneMask = `WP_WORD_ZERO;
			endcase
		end
	endfunction

	reg qualify;
	wire fetchWatch;
	wire [31:0] ignore;
	wire [31:0] lanes;
	wire dataHit;

	always @* begin
		case (funcSel)
		`WP_FUNC_FETCH: qualify = busFetch; // RL11
		`WP_FUNC_READ: qualify = !busFetch && !busWrite; // RL11
		`WP_FUNC_RDWR: qualify = !busFetch; // RL11
		default: qualify = 1'b0;
		endcase
	end

	assign fetchWatch = (funcSel == `WP_FUNC_FETCH);
	assign ignore = ignoreBits(ignoreCount, fetchWatch);
	assign addrHit = (((busAddr ^ refValue) & ~ignore) == `WP_WORD_ZERO); // RL2
	// the reference is replicated, so its own lane lines up with the bus lane
	assign lanes = laneMask(dataSize, busAddr[1:0]); // RL3
	assign dataHit = (lanes != `WP_WORD_ZERO) &&
		(((busData ^ refValue) & lanes) == `WP_WORD_ZERO); // RL2
	// mask count is ignored in data mode, zero is only advised
	assign match = busValid && qualify &&
		(dataMode ? (dataHit && linkGate) : addrHit); // RL12 RL8

endmodule
`default_nettype wire

// ==== logic/watchpoint_unit.v ====
// Purpose: two debug watchpoint comparators behind a classic Wishbone slave
// Assumes: watched core transfers arrive synchronous to mclk
// Notes: one interrupt line from sticky hit events, write one to clear
`timescale 1ns/1ps
`default_nettype none
`include "watchpoint_defines.vh"

//Contract
// RL1: each comparator has a 32-bit reference at 0x20+16i, reset zero, and a mask at 0x24+16i.
// RL2: the reference register is what the comparator checks address or data against.
// RL3: software replicates byte or halfword data across all lanes of the reference.
// RL4: mask bits 31..5 and function bits 31..25 read zero; the mask holds an ignore count.
// RL5: a zero ignore count compares all address bits, except bit 0 on a fetch watch.
// RL6: a nonzero count x drops address bits x-1..0 and matches the range of bits 31..x.
// RL7: the ignore count tops out at 24 and a larger write stores 24.
// RL8: software should leave comparator 0's mask at zero in data mode.
// RL9: function bit 24 is a read-only hit flag, set if a match happened since the last read.
// RL10: reading the function register clears the hit flag, but a same-cycle match keeps it.
// RL11: function codes 0000 off, 0100 fetch, 0110 data read, 0111 data read or write.
// RL12: comparator 0 matches address or data by its data-match bit; comparator 1 addresses only.
// RL13: data size 00 byte, 01 halfword, 10 word, 11 reserved.
// RL14: enabled comparators judge each transfer when presented and set the hit the next cycle.
module watchpoint_unit (
	input wire mclk,
	input wire resetn,
	input wire clkEn,
	input wire wbCyc,
	input wire wbStb,
	input wire wbWe,
	input wire [11:0] wbAdr,
	input wire [3:0] wbSel,
	input wire [31:0] wbDatW,
	output reg [31:0] wbDatR,
	output reg wbAck,
	input wire busValid,
	input wire busFetch,
	input wire busWrite,
	input wire [31:0] busAddr,
	input wire [31:0] busData,
	output wire irq
);

	// byte-lane merge for a Wishbone write
	function [31:0] mergeSel;
		input [31:0] oldValue;
		input [31:0] newValue;
		input [3:0] sel;
		integer i;
		begin
			mergeSel = oldValue;
			for (i = 0; i < 4; i = i + 1) begin
				if (sel[i]) begin
					mergeSel[i*8 +: 8] = newValue[i*8 +: 8];
				end
			end
		end
	endfunction

	// writes above the top count are pinned at the top
	function [4:0] clampCount;
		input [31:0] value;
		begin
			if (value[`WP_MASK_FREE] != 27'h000_0000 ||
				value[`WP_MASK_CNT] > `WP_CNT_MAX) begin
				clampCount = `WP_CNT_MAX; // RL7
			end else begin
				clampCount = value[`WP_MASK_CNT]; // RL7
			end
		end
	endfunction

	function [31:0] maskWord;
		input [4:0] cnt;
		begin
			maskWord = `WP_WORD_ZERO;
			maskWord[`WP_MASK_CNT] = cnt; // RL4
		end
	endfunction

	reg [31:0] refValue0;
	reg [31:0] refValue1;
	reg [4:0] ignoreCount0;
	reg [4:0] ignoreCount1;
	reg [3:0] funcSel0;
	reg [3:0] funcSel1;
	reg dataMode0;
	reg [1:0] dataSize0;
	reg linkAddr0;
	reg hitFlag0;
	reg hitFlag1;
	reg [1:0] irqStatus;
	reg [1:0] irqMask;

	reg [31:0] next_wbDatR;
	reg [31:0] fctWord0;
	reg [31:0] fctWord1;
	reg [31:0] writeWord;

	wire request;
	wire doWrite;
	wire doRead;
	wire match0;
	wire match1;
	wire addrHit1;
	wire linkGate0;
	wire readFct0;
	wire readFct1;
	wire [1:0] hitEvents;
	wire [1:0] clearBits;
	wire wrComp0;
	wire wrComp1;
	wire wrMask0;
	wire wrMask1;
	wire wrFct0;
	wire wrFct1;
	wire wrStatus;
	wire wrIrqMask;

	// one access per request: a second is held off while ack is up
	assign request = wbCyc && wbStb && !wbAck && clkEn;
	assign doWrite = request && wbWe;
	assign doRead = request && !wbWe;
	assign readFct0 = doRead && (wbAdr == `WP_OFF_FCT0);
	assign readFct1 = doRead && (wbAdr == `WP_OFF_FCT1);

	// write strobes, one per register word
	assign wrComp0 = doWrite && (wbAdr == `WP_OFF_COMP0);
	assign wrComp1 = doWrite && (wbAdr == `WP_OFF_COMP1);
	assign wrMask0 = doWrite && (wbAdr == `WP_OFF_MASK0);
	assign wrMask1 = doWrite && (wbAdr == `WP_OFF_MASK1);
	assign wrFct0 = doWrite && (wbAdr == `WP_OFF_FCT0);
	assign wrFct1 = doWrite && (wbAdr == `WP_OFF_FCT1);
	assign wrStatus = doWrite && (wbAdr == `WP_OFF_IRQ_STATUS);
	assign wrIrqMask = doWrite && (wbAdr == `WP_OFF_IRQ_MASK);

	// linked mode: comparator 1 supplies the address for a data watch
	assign linkGate0 = !linkAddr0 || addrHit1;

	watch_comparator compare0 (
		.refValue(refValue0),
		.ignoreCount(ignoreCount0),
		.funcSel(funcSel0),
		.dataMode(dataMode0),
		.dataSize(dataSize0),
		.linkGate(linkGate0),
		.busValid(busValid),
		.busFetch(busFetch),
		.busWrite(busWrite),
		.busAddr(busAddr),
		.busData(busData),
		.addrHit(),
		.match(match0)
	);

	// comparator 1 has no data mode
	watch_comparator compare1 (
		.refValue(refValue1),
		.ignoreCount(ignoreCount1),
		.funcSel(funcSel1),
		.dataMode(1'b0), // RL12
		.dataSize(`WP_SIZE_RESET),
		.linkGate(1'b1),
		.busValid(busValid),
		.busFetch(busFetch),
		.busWrite(busWrite),
		.busAddr(busAddr),
		.busData(busData),
		.addrHit(addrHit1),
		.match(match1)
	);

	always @* begin
		fctWord0 = `WP_WORD_ZERO; // RL4
		fctWord0[`WP_FCT_FUNC] = funcSel0;
		fctWord0[`WP_FCT_DMATCH] = dataMode0;
		fctWord0[`WP_FCT_DSIZE] = dataSize0;
		fctWord0[`WP_FCT_LINK] = linkAddr0;
		fctWord0[`WP_FCT_HIT] = hitFlag0; // RL9
	end

	always @* begin
		fctWord1 = `WP_WORD_ZERO; // RL4
		fctWord1[`WP_FCT_FUNC] = funcSel1;
		fctWord1[`WP_FCT_HIT] = hitFlag1; // RL9
	end

	always @* begin
		case (wbAdr)
		`WP_OFF_COMP0: next_wbDatR = refValue0;
		`WP_OFF_MASK0: next_wbDatR = maskWord(ignoreCount0);
		`WP_OFF_FCT0: next_wbDatR = fctWord0;
		`WP_OFF_COMP1: next_wbDatR = refValue1;
		`WP_OFF_MASK1: next_wbDatR = maskWord(ignoreCount1);
		`WP_OFF_FCT1: next_wbDatR = fctWord1;
		`WP_OFF_IRQ_STATUS: next_wbDatR = {30'h0000_0000, irqStatus};
		`WP_OFF_IRQ_MASK: next_wbDatR = {30'h0000_0000, irqMask};
		// unmapped words still answer, reading zero
		default: next_wbDatR = `WP_WORD_ZERO;
		endcase
	end

	always @* begin
		writeWord = mergeSel(`WP_WORD_ZERO, wbDatW, wbSel);
	end

	// bus handshake and read data
	always @(posedge mclk) begin
		if (!resetn) begin
			wbAck <= 1'b0;
			wbDatR <= `WP_WORD_ZERO;
		end else if (clkEn) begin
			wbAck <= request;
			if (doRead) begin
				wbDatR <= next_wbDatR;
			end
		end
	end

	// reference registers, byte enables honoured
	always @(posedge mclk) begin
		if (!resetn) begin
			refValue0 <= `WP_REF_RESET; // RL1
			refValue1 <= `WP_REF_RESET; // RL1
		end else begin
			if (wrComp0) begin
				refValue0 <= mergeSel(refValue0, wbDatW, wbSel); // RL1
			end
			if (wrComp1) begin
				refValue1 <= mergeSel(refValue1, wbDatW, wbSel); // RL1
			end
		end
	end

	// ignore counts; a partial write clamps what it sees
	always @(posedge mclk) begin
		if (!resetn) begin
			ignoreCount0 <= `WP_CNT_RESET;
			ignoreCount1 <= `WP_CNT_RESET;
		end else begin
			if (wrMask0 && wbSel[0]) begin
				ignoreCount0 <= clampCount(writeWord); // RL7
			end
			if (wrMask1 && wbSel[0]) begin
				ignoreCount1 <= clampCount(writeWord); // RL7
			end
		end
	end

	// function fields
	always @(posedge mclk) begin
		if (!resetn) begin
			funcSel0 <= `WP_FUNC_RESET;
			funcSel1 <= `WP_FUNC_RESET;
			dataMode0 <= 1'b0;
			dataSize0 <= `WP_SIZE_RESET;
			linkAddr0 <= 1'b0;
		end else begin
			if (wrFct0) begin
				if (wbSel[0]) begin
					funcSel0 <= wbDatW[`WP_FCT_FUNC]; // RL11
				end
				if (wbSel[1]) begin
					dataMode0 <= wbDatW[`WP_FCT_DMATCH]; // RL12
					dataSize0 <= wbDatW[`WP_FCT_DSIZE]; // RL13
					linkAddr0 <= wbDatW[`WP_FCT_LINK];
				end
			end
			if (wrFct1 && wbSel[0]) begin
				funcSel1 <= wbDatW[`WP_FCT_FUNC]; // RL11
			end
		end
	end

	// hit flags: a match lands one edge after the transfer, and wins
	// over the clear that a read of the function register brings
	always @(posedge mclk) begin
		if (!resetn) begin
			hitFlag0 <= 1'b0;
			hitFlag1 <= 1'b0;
		end else if (clkEn) begin
			hitFlag0 <= match0 || (hitFlag0 && !readFct0); // RL14 RL10
			hitFlag1 <= match1 || (hitFlag1 && !readFct1); // RL14 RL10
		end
	end

	assign hitEvents = {match1, match0};
	assign clearBits = (wrStatus && wbSel[0]) ?
		wbDatW[1:0] : `WP_IRQ_RESET;

	// sticky status, write one to clear; a new event beats the clear
	always @(posedge mclk) begin
		if (!resetn) begin
			irqStatus <= `WP_IRQ_RESET;
			irqMask <= `WP_IRQ_RESET;
		end else if (clkEn) begin
			irqStatus <= hitEvents | (irqStatus & ~clearBits);
			if (wrIrqMask && wbSel[0]) begin
				irqMask <= wbDatW[1:0];
			end
		end
	end

	assign irq = |(irqStatus & irqMask);

endmodule
`default_nettype wire

// ==== verif/watchpoint_unit_chk.sv ====
// Purpose: port assertions for the watchpoint unit
// Assumes: one clock, synchronous active-low reset
// Notes: bound to every watchpoint_unit instance
`timescale 1ns/1ps
`default_nettype none
module watchpoint_unit_chk (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic clkEn,
	input wire logic wbCyc,
	input wire logic wbStb,
	input wire logic wbWe,
	input wire logic [11:0] wbAdr,
	input wire logic [31:0] wbDatR,
	input wire logic wbAck,
	input wire logic busValid,
	input wire logic irq
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	wire logic rd = wbAck && !wbWe;
	wire logic rdMask = rd && (wbAdr == 12'h024 || wbAdr == 12'h034);
	wire logic rdFct = rd && (wbAdr == 12'h028 || wbAdr == 12'h038);
	property p_ackAnswer;
		wbCyc && wbStb && !wbAck && clkEn |=> wbAck;
	endproperty
	a_ackAnswer: assert property (p_ackAnswer) else $error("ack late");
	property p_ackPulse;
		wbAck && clkEn |=> !wbAck;
	endproperty
	a_ackPulse: assert property (p_ackPulse) else $error("ack long");
	property p_resetState;
		$rose(resetn) |-> !wbAck && !irq && wbDatR == 32'h0000_0000;
	endproperty
	a_resetState: assert property (p_resetState) else $error("reset");
	property p_maskRsv;
		rdMask |-> wbDatR[31:5] == 27'h000_0000;
	endproperty
	a_maskRsv: assert property (p_maskRsv) else $error("mask high");
	property p_maskCap;
		rdMask |-> wbDatR[4:0] <= 5'h18;
	endproperty
	a_maskCap: assert property (p_maskCap) else $error("mask cap");
	property p_fctRsv;
		rdFct |-> wbDatR[31:25] == 7'h00;
	endproperty
	a_fctRsv: assert property (p_fctRsv) else $error("fct high");
	property p_fct1Zero;
		rd && wbAdr == 12'h038 |-> wbDatR[23:4] == 20'h0_0000;
	endproperty
	a_fct1Zero: assert property (p_fct1Zero) else $error("fct1 bits");
	property p_irqCause;
		$rose(irq) |-> $past(busValid) || (wbAck && wbWe);
	endproperty
	a_irqCause: assert property (p_irqCause) else $error("irq cause");
	c_irq: cover property ($rose(irq));
	c_hit: cover property (rdFct && wbDatR[24]);
	c_cap: cover property (rdMask && wbDatR[4:0] == 5'h18);
endmodule
bind watchpoint_unit watchpoint_unit_chk u_chk (.mclk, .resetn, .clkEn,
	.wbCyc, .wbStb, .wbWe, .wbAdr, .wbDatR, .wbAck, .busValid, .irq);
`default_nettype wire

// ==== verif/core_bus_model.sv ====
// Purpose: watched core bus, one transfer per request
// Assumes: go is a one-cycle request from the bench
// Notes: idle lines toggle so stale values never pass
`timescale 1ns/1ps
`default_nettype none
module core_bus_model (
	input wire logic mclk,
	input wire logic go,
	input wire logic [1:0] kind,
	input wire logic [31:0] addr,
	input wire logic [31:0] data,
	output logic busValid = 1'b0,
	output logic busFetch = 1'b0,
	output logic busWrite = 1'b0,
	output logic [31:0] busAddr = 32'h0000_0000,
	output logic [31:0] busData = 32'h0000_0000
);
	always @(posedge mclk) begin
		busValid <= go;
		busFetch <= go ? kind == 2'd0 : ~busFetch;
		busWrite <= go ? kind == 2'd2 : ~busWrite;
		busAddr <= go ? addr : ~busAddr;
		busData <= go ? data : ~busData;
	end
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
// Purpose: self-checking bench for the watchpoint unit
// Assumes: clkEn held high throughout
// Notes: expected address hits come from the match model below
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic mclk = 0, resetn = 0, wbCyc = 0, wbStb = 0, wbWe = 0, go = 0, e;
	logic [11:0] wbAdr = 12'h000;
	logic [3:0] wbSel = 4'hF;
	logic [1:0] kind = 2'd0;
	logic [31:0] wbDatW = 0, addr = 0, data = 0, rd, r0, r1, a, rf;
	logic [31:0] offs [0:4] = '{32'h0000_0001, 32'h0000_0080,
		32'h0000_0100, 32'h0080_0000, 32'h0100_0000};
	integer cnts [0:2] = '{0, 8, 31};
	integer fc [0:3] = '{4, 6, 7, 0};
	integer err_total = 0, checks_done = 0, seed = 8278, f, k, c, n, x, cm;
	wire busValid, busFetch, busWrite, wbAck, irq;
	wire [31:0] busAddr, busData, wbDatR;
	watchpoint_unit DUT (.mclk, .resetn, .clkEn(1'b1), .wbCyc, .wbStb, .wbWe,
		.wbAdr, .wbSel, .wbDatW, .wbDatR, .wbAck, .busValid, .busFetch,
		.busWrite, .busAddr, .busData, .irq);
	core_bus_model u_core (.mclk, .go, .kind, .addr, .data, .busValid,
		.busFetch, .busWrite, .busAddr, .busData);
	initial forever #2.5 mclk = ~mclk;
	function logic ahit(input [31:0] r, input [31:0] a, input integer cm,
		input integer f, input integer k);
		logic [31:0] m;
		begin
			m = cm != 0 ? 32'hFFFF_FFFF << cm :
				f == 4 ? 32'hFFFF_FFFE : 32'hFFFF_FFFF;
			ahit = (r & m) == (a & m) &&
				(f == 4 ? k == 0 : f == 6 ? k == 1 : f == 7 && k != 0);
		end
	endfunction
	task chk(input string nm, input [31:0] ex, input [31:0] got);
		begin
			checks_done++;
			if (got !== ex) begin
				err_total++;
				$display("wrong value %s exp %h got %h", nm, ex, got);
			end
		end
	endtask
	task bus(input w, input [11:0] ad, input [31:0] d);
		begin
			@(posedge mclk);
			wbCyc <= 1; wbStb <= 1; wbWe <= w; wbAdr <= ad; wbDatW <= d;
			@(posedge mclk);
			while (wbAck !== 1'b1) @(posedge mclk);
			rd = wbDatR;
			wbCyc <= 0; wbStb <= 0;
		end
	endtask
	task probe(input [1:0] kd, input [31:0] ad, input [31:0] d);
		begin
			@(posedge mclk);
			go <= 1; kind <= kd; addr <= ad; data <= d;
			@(posedge mclk);
			go <= 0;
		end
	endtask
	task complete_run;
		begin
			$display("checks %0d mismatches %0d", checks_done, err_total);
			if (err_total == 0 && checks_done > 0) $display("Finished cleanly");
			else $display("Finished with errors");
			$finish;
		end
	endtask
	initial begin
		repeat (60000) @(posedge mclk);
		err_total++;
		complete_run;
	end
	initial begin
		repeat (12) @(posedge mclk);
		resetn <= 1;
		for (n = 0; n < 10; n++) begin
			bus(0, 12'h020 + 4 * n, 0);
			chk("reset", 32'h0000_0000, rd);
		end
		$display("test reset done");
		r0 = $random(seed);
		r1 = $random(seed);
		bus(1, 12'h020, r0);
		bus(1, 12'h030, r1);
		bus(0, 12'h020, 0);
		chk("ref0", r0, rd);
		bus(0, 12'h030, 0);
		chk("ref1", r1, rd);
		bus(1, 12'h044, 32'h0000_0003);
		for (c = 0; c < 2; c++) for (f = 0; f < 4; f++) for (n = 0; n < 3; n++) begin
			bus(1, 12'h024 + 16 * c, cnts[n]);
			bus(0, 12'h024 + 16 * c, 0);
			cm = cnts[n] > 24 ? 24 : cnts[n];
			chk("mask", cm, rd);
			bus(1, 12'h028 + 16 * c, fc[f]);
			for (k = 0; k < 3; k++) for (x = 0; x < 5; x++) begin
				a = (c ? r1 : r0) ^ offs[x];
				probe(k, a, $random(seed));
				e = ahit(c ? r1 : r0, a, cm, fc[f], k);
				bus(0, 12'h028 + 16 * c, 0);
				chk("fct", {7'h00, e, 20'h0_0000, fc[f][3:0]}, rd);
				chk("irq", {31'h0000_0000, e}, {31'h0000_0000, irq});
				bus(1, 12'h040, 32'h0000_0003);
			end
		end
		$display("test address done");
		bus(1, 12'h024, 0);
		for (n = 0; n < 3; n++) begin
			rf = n == 0 ? {4{r0[7:0]}} : n == 1 ? {2{r0[15:0]}} : r0;
			bus(1, 12'h020, rf);
			bus(1, 12'h028, 32'h0000_0107 | (n << 10));
			for (x = 0; x < 3; x++) begin
				probe(2, {r1[31:2], 2'b00}, rf ^ (x == 1 ? 32'h0000_0001 :
					x == 2 ? 32'h0100_0000 : 32'h0000_0000));
				e = x == 0 || (x == 2 && n != 2);
				bus(0, 12'h028, 0);
				chk("data", {7'h00, e, 12'h000, n[1:0], 2'b01, 8'h07}, rd);
				bus(1, 12'h040, 32'h0000_0003);
			end
		end
		$display("test data done");
		bus(1, 12'h044, 0);
		probe(2, {r1[31:2], 2'b00}, rf);
		repeat (2) @(posedge mclk);
		chk("irq masked", 32'h0000_0000, {31'h0000_0000, irq});
		bus(0, 12'h040, 0);
		chk("status", 32'h0000_0001, rd);
		$display("test interrupt done");
		complete_run;
	end
endmodule
`default_nettype wire
